// ---- logic/imf_params.svh ----
// Purpose: constants for the interrupt mask and flag register block
// Assumes: register index times four is the byte address on the bus
// Notes  : definitions only
`ifndef IMF_PARAMS_SVH
`define IMF_PARAMS_SVH

// ----------------------------------------------------------------
// register indexes (byte address = 4 * index)
// ----------------------------------------------------------------
`define IMF_IDX_CPU_IRQ_EN     8'hE4
`define IMF_IDX_GROUP_EDGE     8'hE5
`define IMF_IDX_SINGLE_EDGE    8'hE6
`define IMF_IDX_TUNE_MASK      8'hE7
`define IMF_IDX_GROUP_MASK     8'hE8
`define IMF_IDX_SINGLE_MASK    8'hE9
`define IMF_IDX_SW_MASK        8'hEA
`define IMF_IDX_CT_MASK        8'hEB
`define IMF_IDX_TUNE_FLAG      8'hEC
`define IMF_IDX_INPUT_FLAG     8'hED
`define IMF_IDX_SW_FLAG        8'hEE
`define IMF_IDX_CT_FLAG        8'hEF

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define IMF_BIT_GROUP          0
`define IMF_BIT_SINGLE         1
`define IMF_RST_NIB            4'h0
`define IMF_RST_CT             3'h0
`define IMF_RST_SW             2'h0
`define IMF_RST_BIT            1'b0
`define IMF_RST_WORD           32'h0000_0000

`endif

// ---- logic/imf_pkg.sv ----
// Purpose: shared types of the interrupt mask and flag register block
// Assumes: nothing
// Notes  : constants live in imf_params.svh
package imf_pkg;
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic {IMF_ST_IDLE, IMF_ST_ACCESS} imf_state_t;  // bus slave phase
   typedef logic [31:0] imf_word_t;                               // bus data word
endpackage

// ---- logic/imf_edge_det.sv ----
// Purpose: per-bit edge detector with rising/falling select
// Assumes: inputs synchronous to the clock
// Notes  : no edge is reported in the first cycle after reset
`timescale 1ns/1ps
`default_nettype none
module imf_edge_det #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         nrst_i,
   input  wire logic [W-1:0] sig_i,       // sampled level
   input  wire logic [W-1:0] fall_sel_i,  // 1 falling, 0 rising
   output logic      [W-1:0] pulse_o      // one-cycle edge pulse
);
   logic [W-1:0] prev_q;   // level one cycle ago
   logic         seen_q;   // prev_q holds a real sample

   // ----------------------------------------------------------------
   // history
   // ----------------------------------------------------------------
   // seen_q masks the reset value so a high input is not taken as an edge
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         prev_q <= '0;
         seen_q <= 1'b0;
      end
      else
      begin
         prev_q <= sig_i;
         seen_q <= 1'b1;
      end
   end

   // selected edge per bit
   always_comb
   begin
      for (int i = 0; i < W; i++)
      begin
         pulse_o[i] = seen_q & (fall_sel_i[i] ? (prev_q[i] & ~sig_i[i])
                                              : (~prev_q[i] & sig_i[i]));
      end
   end
endmodule
`default_nettype wire

// ---- logic/imf_regs.sv ----
// Purpose: interrupt mask and factor flag registers behind an AHB-Lite slave
// Assumes: event inputs synchronous to CLK_I; single word transfers
// Notes  : every access has one wait state; flags clear on read
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "imf_params.svh"

module imf_regs (
   input  wire logic              CLK_I,
   input  wire logic              NRST_I,
   // ahb-lite slave
   input  wire logic              HSEL_I,
   input  wire logic [31:0]       HADDR_I,
   input  wire logic [1:0]        HTRANS_I,
   input  wire logic              HWRITE_I,
   input  wire logic [2:0]        HSIZE_I,
   input  wire logic              HREADY_I,
   input  wire imf_pkg::imf_word_t HWDATA_I,
   output imf_pkg::imf_word_t     HRDATA_O,
   output logic                   HREADYOUT_O,
   output logic                   HRESP_O,
   // event sources
   input  wire logic [2:0]        CT_TICK_I,        // 2/8/32 Hz clock-timer levels
   input  wire logic [1:0]        SW_TICK_I,        // 1/10 Hz stopwatch levels
   input  wire logic              TUNE_END_I,       // melody end pulse
   input  wire logic [3:0]        INPUT_PIN_GROUP_I,
   input  wire logic              SINGLE_INPUT_PIN_I,
   // cpu side
   input  wire logic              IRQ_ACK_I,        // cpu takes the interrupt
   output logic                   IRQ_O             // level request
);
   import imf_pkg::*;

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   imf_state_t  state_q;            // bus phase
   logic [7:0]  idx_q;              // captured register index
   logic        wr_q;               // captured direction
   imf_word_t   hrdata_q;           // read data
   logic        hready_q;           // ready to bus
   logic        irq_q;              // request to cpu
   logic        ei_q;               // cpu interrupt enable
   logic [3:0]  group_edge_q;       // pin_group_edge_sel
   logic        single_edge_q;      // single_pin_edge_sel
   logic        tune_mask_q;        // tune_end_mask
   logic [3:0]  group_mask_q;       // pin_group_masks
   logic        single_mask_q;      // single_pin_mask
   logic [1:0]  sw_mask_q;          // sw_slow_mask, sw_fast_mask
   logic [2:0]  ct_mask_q;          // ct_slow/mid/fast_mask
   logic        tune_flag_q;        // tune_end_flag
   logic        group_flag_q;       // pin_group_flag
   logic        single_flag_q;      // single_pin_flag
   logic [1:0]  sw_flag_q;          // sw_slow_flag, sw_fast_flag
   logic [2:0]  ct_flag_q;          // ct_slow/mid/fast_flag
   logic        take;               // address phase accepted
   logic        acc_wr;             // write performed this cycle
   logic        acc_rd;             // read performed this cycle
   imf_word_t   rd_word;            // read mux
   logic [2:0]  ct_set;             // clock-timer falling edges
   logic [1:0]  sw_set;             // stopwatch falling edges
   logic [3:0]  grp_edge;           // group pin edges
   logic        sgl_edge;           // single pin edge
   logic        grp_set;            // group flag set
   logic        pending;            // any unmasked flag

   // ----------------------------------------------------------------
   // bus slave
   // ----------------------------------------------------------------
   // only htrans[1] matters: NONSEQ and SEQ are both real transfers
   assign take   = (state_q == IMF_ST_IDLE) & HSEL_I & HTRANS_I[1] & HREADY_I;
   assign acc_wr = (state_q == IMF_ST_ACCESS) & wr_q;
   assign acc_rd = (state_q == IMF_ST_ACCESS) & ~wr_q;

   // phase tracking; one wait state lets read data come from a flop
   always_ff @(posedge CLK_I)
   begin
      if (!NRST_I)
      begin
         state_q  <= IMF_ST_IDLE;
         idx_q    <= 8'h00;
         wr_q     <= 1'b0;
         hready_q <= 1'b1;
      end
      else
      begin
         case (state_q)
            IMF_ST_IDLE:
            begin
               if (take)
               begin
                  // haddr[31:10] ignored: the block aliases across its select
                  idx_q    <= HADDR_I[9:2];
                  wr_q     <= HWRITE_I;
                  hready_q <= 1'b0;
                  state_q  <= IMF_ST_ACCESS;
               end
            end
            IMF_ST_ACCESS:
            begin
               hready_q <= 1'b1;
               state_q  <= IMF_ST_IDLE;
            end
            default:
            begin
               hready_q <= 1'b1;
               state_q  <= IMF_ST_IDLE;
            end
         endcase
      end
   end

   // read mux; unmapped indexes read zero, unused bits read zero
   always_comb
   begin
      rd_word = `IMF_RST_WORD;
      case (idx_q)
         `IMF_IDX_CPU_IRQ_EN:  rd_word[0]   = ei_q;
         `IMF_IDX_GROUP_EDGE:  rd_word[3:0] = group_edge_q;
         `IMF_IDX_SINGLE_EDGE: rd_word[0]   = single_edge_q;
         `IMF_IDX_TUNE_MASK:   rd_word[0]   = tune_mask_q;
         `IMF_IDX_GROUP_MASK:  rd_word[3:0] = group_mask_q;
         `IMF_IDX_SINGLE_MASK: rd_word[0]   = single_mask_q;
         `IMF_IDX_SW_MASK:     rd_word[1:0] = sw_mask_q;
         `IMF_IDX_CT_MASK:     rd_word[2:0] = ct_mask_q;
         `IMF_IDX_TUNE_FLAG:   rd_word[0]   = tune_flag_q;
         `IMF_IDX_INPUT_FLAG:
         begin
            rd_word[`IMF_BIT_SINGLE] = single_flag_q;
            rd_word[`IMF_BIT_GROUP]  = group_flag_q;
         end
         `IMF_IDX_SW_FLAG:     rd_word[1:0] = sw_flag_q;
         `IMF_IDX_CT_FLAG:     rd_word[2:0] = ct_flag_q;
         default:              rd_word      = `IMF_RST_WORD;
      endcase
   end

   // read data register, response always okay
   always_ff @(posedge CLK_I)
   begin
      if (!NRST_I)
      begin
         hrdata_q <= `IMF_RST_WORD;
      end
      else if (acc_rd)
      begin
         hrdata_q <= rd_word;
      end
   end

   // ----------------------------------------------------------------
   // mask and edge-select registers
   // ----------------------------------------------------------------
   // writes to flag registers fall through: flags are read-only
   always_ff @(posedge CLK_I)
   begin
      if (!NRST_I)
      begin
         group_edge_q  <= `IMF_RST_NIB;
         single_edge_q <= `IMF_RST_BIT;
         tune_mask_q   <= `IMF_RST_BIT;
         group_mask_q  <= `IMF_RST_NIB;
         single_mask_q <= `IMF_RST_BIT;
         sw_mask_q     <= `IMF_RST_SW;
         ct_mask_q     <= `IMF_RST_CT;
      end
      else if (acc_wr)
      begin
         case (idx_q)
            `IMF_IDX_GROUP_EDGE:  group_edge_q  <= HWDATA_I[3:0];
            `IMF_IDX_SINGLE_EDGE: single_edge_q <= HWDATA_I[0];
            `IMF_IDX_TUNE_MASK:   tune_mask_q   <= HWDATA_I[0];
            `IMF_IDX_GROUP_MASK:  group_mask_q  <= HWDATA_I[3:0];
            `IMF_IDX_SINGLE_MASK: single_mask_q <= HWDATA_I[0];
            `IMF_IDX_SW_MASK:     sw_mask_q     <= HWDATA_I[1:0];
            `IMF_IDX_CT_MASK:     ct_mask_q     <= HWDATA_I[2:0];
            default:
            begin
               ct_mask_q <= ct_mask_q;
            end
         endcase
      end
   end

   // cpu interrupt enable; taking the interrupt wins over a write
   always_ff @(posedge CLK_I)
   begin
      if (!NRST_I)
      begin
         ei_q <= 1'b0;
      end
      else if (IRQ_ACK_I)
      begin
         ei_q <= 1'b0;
      end
      else if (acc_wr && idx_q == `IMF_IDX_CPU_IRQ_EN)
      begin
         ei_q <= HWDATA_I[0];
      end
   end

   // ----------------------------------------------------------------
   // event detection
   // ----------------------------------------------------------------
   // timer sources interrupt on their falling edge
   imf_edge_det #(.W(3)) u_ct_edge (
      .clk_i      (CLK_I),
      .nrst_i     (NRST_I),
      .sig_i      (CT_TICK_I),
      .fall_sel_i (3'h7),
      .pulse_o    (ct_set)
   );

   imf_edge_det #(.W(2)) u_sw_edge (
      .clk_i      (CLK_I),
      .nrst_i     (NRST_I),
      .sig_i      (SW_TICK_I),
      .fall_sel_i (2'h3),
      .pulse_o    (sw_set)
   );

   // pins: edge chosen per pin by the edge-select registers
   imf_edge_det #(.W(4)) u_grp_edge (
      .clk_i      (CLK_I),
      .nrst_i     (NRST_I),
      .sig_i      (INPUT_PIN_GROUP_I),
      .fall_sel_i (group_edge_q),
      .pulse_o    (grp_edge)
   );

   imf_edge_det #(.W(1)) u_sgl_edge (
      .clk_i      (CLK_I),
      .nrst_i     (NRST_I),
      .sig_i      (SINGLE_INPUT_PIN_I),
      .fall_sel_i (single_edge_q),
      .pulse_o    (sgl_edge)
   );

   // only pins enabled in the group mask feed the shared flag
   assign grp_set = |(grp_edge & group_mask_q);

   // ----------------------------------------------------------------
   // factor flags
   // ----------------------------------------------------------------
   // a read clears the flags it returned; a new event in that cycle wins
   always_ff @(posedge CLK_I)
   begin
      if (!NRST_I)
      begin
         tune_flag_q   <= `IMF_RST_BIT;
         group_flag_q  <= `IMF_RST_BIT;
         single_flag_q <= `IMF_RST_BIT;
         sw_flag_q     <= `IMF_RST_SW;
         ct_flag_q     <= `IMF_RST_CT;
      end
      else
      begin
         tune_flag_q   <= (tune_flag_q & ~(acc_rd && idx_q == `IMF_IDX_TUNE_FLAG))
                          | TUNE_END_I;
         group_flag_q  <= (group_flag_q & ~(acc_rd && idx_q == `IMF_IDX_INPUT_FLAG))
                          | grp_set;
         single_flag_q <= (single_flag_q & ~(acc_rd && idx_q == `IMF_IDX_INPUT_FLAG))
                          | sgl_edge;
         sw_flag_q     <= (sw_flag_q & ~{2{acc_rd && idx_q == `IMF_IDX_SW_FLAG}})
                          | sw_set;
         ct_flag_q     <= (ct_flag_q & ~{3{acc_rd && idx_q == `IMF_IDX_CT_FLAG}})
                          | ct_set;
      end
   end

   // ----------------------------------------------------------------
   // interrupt request
   // ----------------------------------------------------------------
   // the group flag already carries the per-pin masks, so any enabled pin gates it
   assign pending = (tune_flag_q & tune_mask_q)
                  | (single_flag_q & single_mask_q)
                  | (group_flag_q & (|group_mask_q))
                  | (|(sw_flag_q & sw_mask_q))
                  | (|(ct_flag_q & ct_mask_q));

   // registered request; dropped at once when the cpu takes it
   always_ff @(posedge CLK_I)
   begin
      if (!NRST_I)
      begin
         irq_q <= 1'b0;
      end
      else
      begin
         irq_q <= pending & ei_q & ~IRQ_ACK_I;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign HRDATA_O    = hrdata_q;
   assign HREADYOUT_O = hready_q;
   assign HRESP_O     = 1'b0;
   assign IRQ_O       = irq_q;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   AST_CT_MASK_WRITE: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      acc_wr && idx_q == `IMF_IDX_CT_MASK |=> ct_mask_q == $past(HWDATA_I[2:0]))
      else $error("clock-timer mask did not take the written value");

   AST_TUNE_UPPER_ZERO: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      acc_rd && idx_q == `IMF_IDX_TUNE_FLAG |=> HRDATA_O[31:1] == 31'h0 && HREADYOUT_O)
      else $error("tune flag read has upper bits set");

   AST_INPUT_READ: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      acc_rd && idx_q == `IMF_IDX_INPUT_FLAG |=>
      HRDATA_O == {30'h0, $past(single_flag_q), $past(group_flag_q)})
      else $error("input flag read data wrong");

   AST_SW_READ: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      acc_rd && idx_q == `IMF_IDX_SW_FLAG |=> HRDATA_O == {30'h0, $past(sw_flag_q)})
      else $error("stopwatch flag read data wrong");

   AST_CT_SET: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      $fell(CT_TICK_I[0]) && $past(NRST_I) |=> ct_flag_q[0])
      else $error("clock-timer fast flag not set on falling edge");

   AST_SW_IRQ: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      sw_flag_q[1] && sw_mask_q[1] && ei_q && !IRQ_ACK_I |=> IRQ_O)
      else $error("unmasked stopwatch flag raised no request");

   AST_TUNE_SET: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      TUNE_END_I |=> tune_flag_q)
      else $error("tune end did not set its flag");

   // the request is registered, so it follows flag, mask and enable by one edge
   AST_TUNE_IRQ: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      tune_flag_q && tune_mask_q && ei_q && !IRQ_ACK_I |=> IRQ_O)
      else $error("unmasked tune flag raised no request");

   AST_GROUP_MASKED: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      !group_flag_q && grp_edge != 4'h0 && (grp_edge & group_mask_q) == 4'h0
      |=> !group_flag_q)
      else $error("masked group pin set the shared flag");

   AST_SINGLE_SET: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      sgl_edge |=> single_flag_q)
      else $error("single pin edge did not set its flag");

   AST_READ_CLEARS: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      acc_rd && idx_q == `IMF_IDX_CT_FLAG && ct_set == 3'h0 |=> ct_flag_q == 3'h0)
      else $error("clock-timer flags not cleared by read");

   AST_IRQ_CAUSE: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      IRQ_O |-> $past(ei_q) && $past(pending))
      else $error("request without enable and unmasked flag");

   AST_ACK_DISABLES: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      IRQ_ACK_I |=> !ei_q && !IRQ_O)
      else $error("taking the interrupt left it enabled");

   AST_SET_WINS: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      acc_rd && idx_q == `IMF_IDX_CT_FLAG && ct_set[0] |=> ct_flag_q[0])
      else $error("event lost against read clear");

   COV_WRITE: cover property (@(posedge CLK_I) disable iff (!NRST_I)
      acc_wr && idx_q == `IMF_IDX_CT_MASK);
   COV_READ_CLEAR: cover property (@(posedge CLK_I) disable iff (!NRST_I)
      acc_rd && idx_q == `IMF_IDX_INPUT_FLAG && (group_flag_q || single_flag_q));
   COV_IRQ: cover property (@(posedge CLK_I) disable iff (!NRST_I)
      IRQ_O ##1 IRQ_ACK_I);
   COV_RACE: cover property (@(posedge CLK_I) disable iff (!NRST_I)
      acc_rd && idx_q == `IMF_IDX_TUNE_FLAG && TUNE_END_I);
endmodule
`default_nettype wire

// ---- sim/imf_cpu_model.sv ----
// Purpose: cpu-side bus master that reads and writes the flag block
// Assumes: single word transfers, one slave whose hreadyout is hready
// Notes  : after the time-zero setup, signals change by non-blocking assignment after an edge
`timescale 1ns/1ps
`default_nettype none
module imf_cpu_model (
   input  wire logic        clk_i,
   input  wire logic        hready_i,
   input  wire logic [31:0] hrdata_i,
   output logic             hsel_o,
   output logic [31:0]      haddr_o,
   output logic [1:0]       htrans_o,
   output logic             hwrite_o,
   output logic [31:0]      hwdata_o,
   output logic             ack_o
);
   // ----------------------------------------------------------------
   // bus idle at time zero
   // ----------------------------------------------------------------
   initial
   begin
      hsel_o   = 1'b0;
      haddr_o  = 32'h0;
      htrans_o = 2'h0;
      hwrite_o = 1'b0;
      hwdata_o = 32'h0;
      ack_o    = 1'b0;
   end
   // one transfer; the index times four is the byte address
   task automatic xfer(input logic w, input logic [7:0] idx,
                       input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk_i);
      hsel_o   <= 1'b1;
      htrans_o <= 2'h2;
      hwrite_o <= w;
      haddr_o  <= {22'h0, idx, 2'h0};
      // address phase held until ready is seen
      do @(posedge clk_i); while (hready_i !== 1'b1);
      hsel_o   <= 1'b0;
      htrans_o <= 2'h0;
      hwdata_o <= wd;
      // data phase held, read data taken at the same edge
      do @(posedge clk_i); while (hready_i !== 1'b1);
      rd = hrdata_i;
   endtask
   // the core takes the interrupt: one-cycle acknowledge
   task automatic take;
      @(posedge clk_i);
      ack_o <= 1'b1;
      @(posedge clk_i);
      ack_o <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ---- sim/interrupt_mask_flag_regs_test.sv ----
// Purpose: self-checking bench for the interrupt mask and flag registers
// Assumes: one wait state per access, event edges land one edge later
// Notes  : a table of register writes, then hand-written event cases
`timescale 1ns/1ps
`default_nettype none
`include "imf_params.svh"
module interrupt_mask_flag_regs_test;
   import imf_pkg::*;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   typedef struct {logic [7:0] idx; logic [31:0] wd; logic [31:0] ex;} imf_row_t;
   logic        clk, nrst, hsel, hwrite, hresp, hready, ack, irq, tune, pin;
   logic [31:0] haddr;
   logic [1:0]  htrans, sw;
   logic [2:0]  ct;
   logic [3:0]  grp;
   imf_word_t   hwdata, hrdata, v;
   int          num_errors, compares;
   imf_row_t    rows [10];
   logic [7:0]  fi [4];
   logic [31:0] fe [4];
   logic [7:0]  mi [5];
   imf_regs DUT (.CLK_I(clk), .NRST_I(nrst), .HSEL_I(hsel), .HADDR_I(haddr),
      .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HREADY_I(hready),
      .HWDATA_I(hwdata), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
      .CT_TICK_I(ct), .SW_TICK_I(sw), .TUNE_END_I(tune), .INPUT_PIN_GROUP_I(grp),
      .SINGLE_INPUT_PIN_I(pin), .IRQ_ACK_I(ack), .IRQ_O(irq));
   imf_cpu_model cpu (.clk_i(clk), .hready_i(hready), .hrdata_i(hrdata),
      .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite),
      .hwdata_o(hwdata), .ack_o(ack));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic rd(input logic [7:0] i, output logic [31:0] d);
      cpu.xfer(1'b0, i, 32'h0, d);
   endtask
   task automatic wr(input logic [7:0] i, input logic [31:0] d);
      logic [31:0] x;
      cpu.xfer(1'b1, i, d, x);
   endtask
   // sources go high: rising edges must not set anything here
   task automatic rise;
      @(posedge clk);
      ct <= 3'h7; sw <= 2'h3; grp <= 4'hF; pin <= 1'b1;
   endtask
   // falling edges on every source plus a one-cycle tune end
   task automatic fall;
      @(posedge clk);
      ct <= 3'h0; sw <= 2'h0; grp <= 4'h0; pin <= 1'b0; tune <= 1'b1;
      @(posedge clk);
      tune <= 1'b0;
   endtask
   task automatic summarize;
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // clock and watchdog; the run needs well under 2000 cycles
   // ----------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      #200000;
      num_errors++;
      $display("[FAIL] watchdog expected done seen hang");
      summarize();
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      nrst = 1'b0; ct = 3'h0; sw = 2'h0; grp = 4'h0; pin = 1'b0; tune = 1'b0;
      num_errors = 0;
      compares = 0;
      rows = '{'{`IMF_IDX_CT_MASK, 32'hF, 32'h7}, '{`IMF_IDX_SW_MASK, 32'hF, 32'h3},
         '{`IMF_IDX_TUNE_MASK, 32'hF, 32'h1}, '{`IMF_IDX_GROUP_MASK, 32'hF, 32'hF},
         '{`IMF_IDX_GROUP_EDGE, 32'hF, 32'hF}, '{`IMF_IDX_SINGLE_MASK, 32'hF, 32'h1},
         '{`IMF_IDX_SINGLE_EDGE, 32'hF, 32'h1}, '{`IMF_IDX_CT_FLAG, 32'hF, 32'h0},
         '{`IMF_IDX_TUNE_FLAG, 32'hF, 32'h0}, '{8'h10, 32'hF, 32'h0}};
      fi = '{`IMF_IDX_CT_FLAG, `IMF_IDX_SW_FLAG, `IMF_IDX_TUNE_FLAG, `IMF_IDX_INPUT_FLAG};
      fe = '{32'h7, 32'h3, 32'h1, 32'h3};
      mi = '{`IMF_IDX_CT_MASK, `IMF_IDX_SW_MASK, `IMF_IDX_TUNE_MASK,
         `IMF_IDX_SINGLE_MASK, `IMF_IDX_GROUP_MASK};
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      for (int i = 8'hE4; i <= 8'hEF; i++)
      begin
         rd(8'(i), v);
         chk("reset value", v, 32'h0);
      end
      $display("test reset values done");
      // writes land in masks and edge selects; flag and unmapped places stay zero
      foreach (rows[k])
      begin
         wr(rows[k].idx, rows[k].wd);
         rd(rows[k].idx, v);
         chk("register", v, rows[k].ex);
      end
      chk("response", 32'(hresp), 32'h0);
      $display("test register table done");
      // both pin edge selects are falling, so rising edges are ignored
      rise();
      rd(`IMF_IDX_INPUT_FLAG, v);
      chk("rising ignored", v, 32'h0);
      fall();
      foreach (fi[k])
      begin
         rd(fi[k], v);
         chk("flag", v, fe[k]);
         rd(fi[k], v);
         chk("cleared", v, 32'h0);
      end
      $display("test flags done");
      // pending flags, all masks off: no request even when enabled
      rise();
      fall();
      foreach (mi[k]) wr(mi[k], 32'h0);
      wr(`IMF_IDX_CPU_IRQ_EN, 32'h1);
      repeat (3) @(posedge clk);
      #1 chk("masked", 32'(irq), 32'h0);
      wr(`IMF_IDX_CPU_IRQ_EN, 32'h0);
      foreach (mi[k])
      begin
         wr(mi[k], 32'hF); // masks are touched only while disabled
         wr(`IMF_IDX_CPU_IRQ_EN, 32'h1);
         repeat (2) @(posedge clk);
         #1 chk("request", 32'(irq), 32'h1);
         cpu.take();
         #1 chk("taken", 32'(irq), 32'h0);
         rd(`IMF_IDX_CPU_IRQ_EN, v);
         chk("enable after take", v, 32'h0);
         wr(mi[k], 32'h0);
      end
      $display("test request done");
      // a falling edge lands on the clearing edge of a flag read
      rise();
      rd(`IMF_IDX_CT_FLAG, v);
      fork
         rd(`IMF_IDX_CT_FLAG, v);
         begin
            repeat (2) @(posedge clk);
            ct <= 3'h0;
         end
      join
      rd(`IMF_IDX_CT_FLAG, v);
      chk("set beats clear", v, 32'h7);
      $display("test collision done");
      // rising selects; group pins 3..1 masked off, so only pin 0 counts
      wr(`IMF_IDX_GROUP_EDGE, 32'h0);
      wr(`IMF_IDX_SINGLE_EDGE, 32'h0);
      wr(`IMF_IDX_GROUP_MASK, 32'h1);
      rd(`IMF_IDX_INPUT_FLAG, v);
      @(posedge clk);
      grp <= 4'h0;
      pin <= 1'b0;
      @(posedge clk);
      grp <= 4'hE;
      rd(`IMF_IDX_INPUT_FLAG, v);
      chk("masked or falling", v, 32'h0);
      @(posedge clk);
      grp <= 4'hF;
      pin <= 1'b1;
      rd(`IMF_IDX_INPUT_FLAG, v);
      chk("rising edges", v, 32'h3);
      $display("test edge select done");
      // second reset in mid-run drops a live request, clears mask and flags
      wr(`IMF_IDX_CT_MASK, 32'h7);
      rise();
      fall();
      wr(`IMF_IDX_CPU_IRQ_EN, 32'h1);
      repeat (2) @(posedge clk);
      #1 chk("request before reset", 32'(irq), 32'h1);
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk("irq in reset", 32'(irq), 32'h0);
      @(posedge clk);
      nrst <= 1'b1;
      rd(`IMF_IDX_CT_MASK, v);
      chk("mask after reset", v, 32'h0);
      rd(`IMF_IDX_CT_FLAG, v);
      chk("flags after reset", v, 32'h0);
      $display("test second reset done");
      summarize();
   end
endmodule
`default_nettype wire
